/* tb.sv */
// Register-level tests of the endpoint flag block.
`timescale 1ns/1ps
`include "uepif_defs.vh"
module tb;
localparam C = `UEPIF_CLR_BASE, S = `UEPIF_SET_BASE, T = `UEPIF_STAT_BASE;
localparam M = `UEPIF_MASK_BASE, G = `UEPIF_CFG_BASE, F = `UEPIF_FIFO_BASE;
reg ref_clk_i = 0, rst_i = 1, we = 0, re = 0, slow = 0;
reg [31:0] a = 0, d = 0;
reg [9:0] su = 0, of = 0, uf = 0;
wire [31:0] rd;
wire [9:0] irq, tx, fr, rel, ins;
integer errors = 0, cmp_count = 0, ntx = 0, nfr = 0, nrel = 0;
always #10 ref_clk_i = ~ref_clk_i;
always @(negedge ref_clk_i) begin
	ntx = ntx + $countones(tx);
	nfr = nfr + $countones(fr);
	nrel = nrel + $countones(rel);
end
uepif_flags dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1), .bus_addr_i(a),
	.bus_wdata_i(d), .bus_we_i(we), .bus_re_i(re), .bus_rdata_o(rd), .setup_rx_i(su),
	.out_filled_i(of), .in_sent_i(ins), .underflow_i(uf), .misc_evt_i(50'h0),
	.endpoint_interrupt_o(irq), .tx_send_o(tx), .bank_free_o(fr), .fifo_release_o(rel));
uepif_host host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .slow_i(slow), .tx_send_i(tx),
	.fifo_release_i(rel), .in_ep_i(10'h010), .in_sent_o(ins));
task end_of_test;
	begin
		if (errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
endtask
task ck(input [31:0] s, input [31:0] e);
	begin
		cmp_count = cmp_count + 1;
		if (s !== e) begin
			errors = errors + 1;
			$display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
		end
	end
endtask
task cy(input integer n);
	repeat (n) @(posedge ref_clk_i);
endtask
task w(input [31:0] ad, input [31:0] dt);
	begin
		@(posedge ref_clk_i);
		we <= 1;
		a <= ad;
		d <= dt;
		@(posedge ref_clk_i);
		we <= 0;
	end
endtask
task r(input [31:0] ad, input [31:0] e, input [31:0] m);
	begin
		@(posedge ref_clk_i);
		re <= 1;
		a <= ad;
		@(posedge ref_clk_i);
		re <= 0;
		#1;
		ck(rd & m, e);
	end
endtask
task ev(input [9:0] s, input [9:0] o, input [9:0] u);
	begin
		@(posedge ref_clk_i);
		su <= s;
		of <= o;
		uf <= u;
		@(posedge ref_clk_i);
		su <= 0;
		of <= 0;
		uf <= 0;
		cy(3);
	end
endtask
initial begin
	#100000;
	errors = errors + 1;
	end_of_test;
end
initial begin
	cy(16);
	rst_i <= 0;
	r(T, 32'h1, 32'h18ff);
	r(C, 32'h0, 32'hffffffff);
	r(S + 4, 32'h0, 32'hffffffff);
	w(M, 32'h4);
	ev(10'h1, 10'h0, 10'h0);
	r(T, 32'h5, 32'h18ff);
	ck(irq[0], 1);
	w(C, 32'h0);
	r(T, 32'h5, 32'h18ff);
	w(C, 32'h4);
	cy(2);
	ck(nfr, 1);
	r(T, 32'h1, 32'h18ff);
	ck(irq[0], 0);
	ev(10'h0, 10'h1, 10'h0);
	r(T, 32'h3, 32'h18ff);
	w(C, 32'h2);
	cy(2);
	ck(nfr, 2);
	slow <= 1;
	w(C, 32'h1);
	cy(2);
	ck(ntx, 1);
	r(T, 32'h0, 32'hff);
	cy(12);
	r(T, 32'h1, 32'hff);
	w(S + 4, 32'hf8);
	r(T + 4, 32'hf9, 32'h18ff);
	w(C + 4, 32'hf8);
	r(T + 4, 32'h1, 32'h18ff);
	w(S + 8, 32'h1000);
	r(T + 8, 32'h400, 32'h400);
	w(G + 12, 32'ha);
	r(T + 12, 32'h0, 32'h7fff);
	ev(10'h0, 10'h8, 10'h8);
	r(T + 12, 32'h1d02, 32'h7fff);
	w(C + 12, 32'h2);
	r(T + 12, 32'h1d00, 32'h7fff);
	ck(nrel, 0);
	w(F + 12, 32'h1);
	cy(3);
	ck(nrel, 1);
	r(T + 12, 32'h0, 32'h7fff);
	slow <= 0;
	w(G + 16, 32'he);
	r(T + 16, 32'h1c01, 32'h7fff);
	w(C + 16, 32'h1);
	r(T + 16, 32'h1c00, 32'h7fff);
	w(F + 16, 32'h1);
	cy(5);
	ck(nrel, 2);
	r(T + 16, 32'h1c01, 32'h7fff);
	w(G + 20, 32'h9);
	ev(10'h0, 10'h0, 10'h20);
	r(T + 20, 32'h4, 32'hff);
	end_of_test;
end
endmodule // tb

/* uepif_defs.vh */
// Constants for the endpoint interrupt flag block.
`ifndef UEPIF_DEFS_VH
`define UEPIF_DEFS_VH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define UEPIF_NUM_EP 10
`define UEPIF_NUM_MISC 5

// ----------------------------------------
// Register byte addresses, endpoint x at base plus four times x
// ----------------------------------------
`define UEPIF_CLR_BASE 32'h400ac160
`define UEPIF_SET_BASE 32'h400ac190
`define UEPIF_STAT_BASE 32'h400ac300
`define UEPIF_MASK_BASE 32'h400ac330
`define UEPIF_CFG_BASE 32'h400ac360
`define UEPIF_FIFO_BASE 32'h400ac390
`define UEPIF_EP_STRIDE 32'h00000004

// ----------------------------------------
// Bit positions in clear, set, status, mask and FIFO registers
// ----------------------------------------
`define UEPIF_B_IN_READY 0
`define UEPIF_B_OUT_RX 1
`define UEPIF_B_SETUP 2
`define UEPIF_B_MISC_LO 3
`define UEPIF_B_BUSY_FORCE 12
`define UEPIF_B_FIFO_REL 0

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define UEPIF_S_BUSY_LO 8
`define UEPIF_S_BUSY_IRQ 10
`define UEPIF_S_FIFO_CONTROL_BIT 11
`define UEPIF_S_READ_WRITE_ALLOWED 12
`define UEPIF_S_BANK_LO 13

// ----------------------------------------
// Configuration register fields and endpoint types
// ----------------------------------------
`define UEPIF_C_TYPE_LO 0
`define UEPIF_C_DIR_IN 2
`define UEPIF_C_BANKS_LO 3
`define UEPIF_T_CTRL 2'h0
`define UEPIF_T_ISO 2'h1
`define UEPIF_T_BULK 2'h2
`define UEPIF_T_INTR 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UEPIF_CFG_RST 5'h08
`define UEPIF_MASK_RST 13'h0000
`define UEPIF_FLAG_RST 8'h00

`endif

/* uepif_flags.v */
// Endpoint interrupt flags, bank tracking and register port for endpoints 0 to 9.
//
// Behaviour
// R1: Control SETUP packet sets setup-received flag.
// R2: Clearing setup flag acknowledges and frees bank.
// R3: Setup position zero bulk/interrupt, underflow isochronous.
// R4: Control OUT packet sets OUT-received flag.
// R5: Control OUT-received clear frees the bank.
// R6: Non-control OUT full bank sets flag, FIFO bit.
// R7: Non-control OUT clear only acknowledges; FIFO releases.
// R8: After bank switch flags follow new bank.
// R9: Software clears flag before FIFO control bit.
// R10: OUT-received stays zero on IN endpoints.
// R11: Control free IN bank sets IN-ready flag.
// R12: Control IN-ready clear sends the bank.
// R13: Non-control IN free bank sets flag, FIFO bit.
// R14: Non-control IN clear leaves FIFO; release sends.
// R15: IN-ready stays zero on OUT endpoints.
// R16: Write-only clear register per endpoint 0-9.
// R17: Clear bit one clears matching status flag.
// R18: Write-only set register, bit 12 busy force.
// R19: Set bit forces flag like real event.
// R20: Zero writes ignored, clear/set read zero.
// R21: Control endpoints read FIFO/RW-allowed as zero.
// R22: Interrupt while any enabled flag is set.
`timescale 1ns/1ps
`include "uepif_defs.vh"

module uepif_flags (
	input wire ref_clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire [31:0] bus_addr_i,
	input wire [31:0] bus_wdata_i,
	input wire bus_we_i,
	input wire bus_re_i,
	output reg [31:0] bus_rdata_o,
	input wire [9:0] setup_rx_i,
	input wire [9:0] out_filled_i,
	input wire [9:0] in_sent_i,
	input wire [9:0] underflow_i,
	input wire [49:0] misc_evt_i,
	output reg [9:0] endpoint_interrupt_o,
	output reg [9:0] tx_send_o,
	output reg [9:0] bank_free_o,
	output reg [9:0] fifo_release_o
);

	// ----------------------------------------
	// Per endpoint read views.
	// ----------------------------------------
	wire [32*`UEPIF_NUM_EP-1:0] stat_all;
	wire [32*`UEPIF_NUM_EP-1:0] mask_all;
	wire [32*`UEPIF_NUM_EP-1:0] cfg_all;
	wire [9:0] irq_nxt;
	wire [9:0] send_nxt;
	wire [9:0] bfree_nxt;
	wire [9:0] rel_nxt;

	// ----------------------------------------
	// Per endpoint read address matches.
	// ----------------------------------------
	wire [9:0] stat_hit;
	wire [9:0] mask_hit;
	wire [9:0] cfg_hit;

	genvar i;
	generate
		for (i = 0; i < `UEPIF_NUM_EP; i = i + 1) begin : g_ep
			// ----------------------------------------
			// Endpoint state.
			// ----------------------------------------
			reg [4:0] cfg_r;
			reg [12:0] mask_r;
			reg [7:0] flag_r;
			reg armed_r;
			reg busy_force_r;
			reg [1:0] busy_r;
			reg [1:0] bank_r;
			reg [7:0] flag_nxt;
			reg [1:0] busy_nxt;
			reg [7:0] hw_set;
			reg [7:0] sw_clr;
			reg [7:0] vis;
			reg busy_up;
			reg busy_dn;
			reg avail_after;

			// ----------------------------------------
			// Register addresses of this endpoint.
			// ----------------------------------------
			wire [31:0] a_clr = `UEPIF_CLR_BASE + `UEPIF_EP_STRIDE * i;
			wire [31:0] a_set = `UEPIF_SET_BASE + `UEPIF_EP_STRIDE * i;
			wire [31:0] a_msk = `UEPIF_MASK_BASE + `UEPIF_EP_STRIDE * i;
			wire [31:0] a_cfg = `UEPIF_CFG_BASE + `UEPIF_EP_STRIDE * i;
			wire [31:0] a_fifo = `UEPIF_FIFO_BASE + `UEPIF_EP_STRIDE * i;

			// ----------------------------------------
			// Endpoint type and bank count.
			// ----------------------------------------
			wire [1:0] ep_type = cfg_r[`UEPIF_C_TYPE_LO +: 2];
			wire is_in = cfg_r[`UEPIF_C_DIR_IN];
			wire is_ctrl = (ep_type == `UEPIF_T_CTRL);
			wire is_iso = (ep_type == `UEPIF_T_ISO);
			wire [1:0] nb = (cfg_r[`UEPIF_C_BANKS_LO +: 2] == 2'h0) ? 2'h1 :
				cfg_r[`UEPIF_C_BANKS_LO +: 2];

			// ----------------------------------------
			// Strobe decode.
			// ----------------------------------------
			// R16: Clear register decode.
			wire sel_clr = bus_we_i && (bus_addr_i == a_clr);
			// R18: Set register decode.
			wire sel_set = bus_we_i && (bus_addr_i == a_set);
			wire sel_msk = bus_we_i && (bus_addr_i == a_msk);
			wire sel_cfg = bus_we_i && (bus_addr_i == a_cfg);
			wire sel_fifo = bus_we_i && (bus_addr_i == a_fifo);
			// R20: Zero bits ignored.
			wire [7:0] clr = sel_clr ? bus_wdata_i[7:0] : 8'h00;
			wire [7:0] frc = sel_set ? bus_wdata_i[7:0] : 8'h00;
			wire frc_busy = sel_set & bus_wdata_i[`UEPIF_B_BUSY_FORCE];

			// ----------------------------------------
			// Bank release, send and arming.
			// ----------------------------------------
			// R7: Release of a non-control bank.
			wire rel = sel_fifo & bus_wdata_i[`UEPIF_B_FIFO_REL] & ~is_ctrl & armed_r;
			// R12: Clearing IN-ready sends.
			wire ctrl_send = is_ctrl & clr[`UEPIF_B_IN_READY] & armed_r;
			wire avail = is_ctrl ? (busy_r == 2'h0) :
				(is_in ? (busy_r < nb) : (busy_r != 2'h0));
			// R13: Bank available arms.
			wire arm_set = avail & ~armed_r & ~rel & ~ctrl_send;
			wire armed_nxt = (armed_r & ~rel & ~ctrl_send) | arm_set;
			wire busy_cond = ~is_ctrl & (is_in ? (busy_r == 2'h0) : (busy_r == nb));
			wire busy_irq = busy_cond | busy_force_r;
			wire [7:0] eff = flag_r & vis;

			// ----------------------------------------
			// Busy bank accounting.
			// ----------------------------------------
			always @* begin
				busy_up = 1'b0;
				busy_dn = 1'b0;
				case (ep_type)
					`UEPIF_T_CTRL: begin
						busy_up = ctrl_send;
						busy_dn = in_sent_i[i] & (busy_r != 2'h0);
					end
					default: begin
						if (is_in) begin
							busy_up = rel;
							busy_dn = in_sent_i[i] & (busy_r != 2'h0);
						end else begin
							busy_up = out_filled_i[i] & (busy_r < nb);
							busy_dn = rel;
						end
					end
				endcase
				busy_nxt = busy_r + {1'b0, busy_up} - {1'b0, busy_dn};
				avail_after = is_in ? (busy_nxt < nb) : (busy_nxt != 2'h0);
			end

			// ----------------------------------------
			// Flag update.
			// ----------------------------------------
			always @* begin
				hw_set = 8'h00;
				vis = 8'hff;
				case (ep_type)
					`UEPIF_T_CTRL: begin
						// R11: Control IN bank free.
						hw_set[`UEPIF_B_IN_READY] = arm_set;
						// R4: Control OUT packet.
						hw_set[`UEPIF_B_OUT_RX] = out_filled_i[i];
						// R1: SETUP on control only.
						hw_set[`UEPIF_B_SETUP] = setup_rx_i[i];
					end
					`UEPIF_T_ISO: begin
						// R13: Isochronous IN free bank.
						hw_set[`UEPIF_B_IN_READY] = arm_set & is_in;
						// R6: Isochronous OUT bank full.
						hw_set[`UEPIF_B_OUT_RX] = arm_set & ~is_in;
						// R3: Underflow at setup position.
						hw_set[`UEPIF_B_SETUP] = is_iso & underflow_i[i];
						// R10: OUT flag hidden on IN.
						vis[`UEPIF_B_OUT_RX] = ~is_in;
						// R15: IN flag hidden on OUT.
						vis[`UEPIF_B_IN_READY] = is_in;
					end
					default: begin
						hw_set[`UEPIF_B_IN_READY] = arm_set & is_in;
						hw_set[`UEPIF_B_OUT_RX] = arm_set & ~is_in;
						// R3: Setup position masked to zero here.
						vis[`UEPIF_B_SETUP] = 1'b0;
						vis[`UEPIF_B_OUT_RX] = ~is_in;
						vis[`UEPIF_B_IN_READY] = is_in;
					end
				endcase
				hw_set[7:3] = misc_evt_i[i*`UEPIF_NUM_MISC +: `UEPIF_NUM_MISC];
				// R8: No available bank after release clears flag.
				sw_clr = 8'h00;
				if (rel && !avail_after) begin
					sw_clr[`UEPIF_B_IN_READY] = is_in;
					sw_clr[`UEPIF_B_OUT_RX] = ~is_in;
				end
				// R17: Clear then set.
				// R19: Forced set acts as event.
				flag_nxt = (flag_r & ~(clr | sw_clr)) | hw_set | frc;
			end

			// ----------------------------------------
			// Endpoint registers.
			// ----------------------------------------
			always @(posedge ref_clk_i or posedge rst_i) begin
				if (rst_i) begin
					cfg_r <= `UEPIF_CFG_RST;
					mask_r <= `UEPIF_MASK_RST;
					flag_r <= `UEPIF_FLAG_RST;
					armed_r <= 1'b0;
					busy_force_r <= 1'b0;
					busy_r <= 2'h0;
					bank_r <= 2'h0;
				end else if (ce_i) begin
					if (sel_cfg) begin
						cfg_r <= bus_wdata_i[4:0];
					end
					if (sel_msk) begin
						mask_r <= bus_wdata_i[12:0];
					end
					flag_r <= flag_nxt;
					armed_r <= armed_nxt;
					busy_r <= busy_nxt;
					busy_force_r <= frc_busy | (busy_force_r & ~rel);
					// R14: Release advances bank.
					if (rel) begin
						bank_r <= (bank_r >= nb - 2'h1) ? 2'h0 : bank_r + 2'h1;
					end
					// A new configuration restarts the endpoint with empty banks.
					if (sel_cfg) begin
						flag_r <= `UEPIF_FLAG_RST;
						armed_r <= 1'b0;
						busy_force_r <= 1'b0;
						busy_r <= 2'h0;
						bank_r <= 2'h0;
					end
				end
			end

			// ----------------------------------------
			// Read views and pulses.
			// ----------------------------------------
			// R21: Control reads FIFO bits zero.
			wire fifo_bit = armed_r & ~is_ctrl;
			wire rw_allowed = fifo_bit & avail;
			assign stat_all[i*32 +: 32] = {17'h00000, bank_r, rw_allowed,
				fifo_bit, busy_irq, busy_r, eff};
			assign stat_hit[i] = (bus_addr_i == `UEPIF_STAT_BASE + `UEPIF_EP_STRIDE * i);
			assign mask_hit[i] = (bus_addr_i == `UEPIF_MASK_BASE + `UEPIF_EP_STRIDE * i);
			assign cfg_hit[i] = (bus_addr_i == `UEPIF_CFG_BASE + `UEPIF_EP_STRIDE * i);
			assign mask_all[i*32 +: 32] = {19'h00000, mask_r};
			assign cfg_all[i*32 +: 32] = {27'h0000000, cfg_r};
			// R22: Enabled flag raises interrupt.
			wire flag_hit = |(eff & mask_r[7:0]);
			wire busy_hit = busy_irq & mask_r[`UEPIF_B_BUSY_FORCE];
			assign irq_nxt[i] = flag_hit | busy_hit;
			assign send_nxt[i] = ctrl_send;
			// R2: Setup clear frees bank.
			// R5: OUT clear frees bank.
			assign bfree_nxt[i] = is_ctrl & ((clr[`UEPIF_B_SETUP] & flag_r[`UEPIF_B_SETUP]) |
				(clr[`UEPIF_B_OUT_RX] & flag_r[`UEPIF_B_OUT_RX]));
			assign rel_nxt[i] = rel;
		end
	endgenerate

	// ----------------------------------------
	// Read data, one cycle after the strobe.
	// ----------------------------------------
	reg [31:0] rd_nxt;
	integer k;
	always @* begin
		rd_nxt = 32'h00000000;
		// R20: Clear and set read zero.
		for (k = 0; k < `UEPIF_NUM_EP; k = k + 1) begin
			if (stat_hit[k]) begin
				rd_nxt = stat_all[k*32 +: 32];
			end
			if (mask_hit[k]) begin
				rd_nxt = mask_all[k*32 +: 32];
			end
			if (cfg_hit[k]) begin
				rd_nxt = cfg_all[k*32 +: 32];
			end
		end
	end

	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bus_rdata_o <= 32'h00000000;
		end else if (ce_i) begin
			bus_rdata_o <= bus_re_i ? rd_nxt : 32'h00000000;
		end
	end

	// ----------------------------------------
	// Endpoint interrupt lines.
	// ----------------------------------------
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			endpoint_interrupt_o <= 10'h000;
		end else if (ce_i) begin
			endpoint_interrupt_o <= irq_nxt;
		end
	end

	// ----------------------------------------
	// Control send pulses.
	// ----------------------------------------
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_send_o <= 10'h000;
		end else if (ce_i) begin
			tx_send_o <= send_nxt;
		end
	end

	// ----------------------------------------
	// Control bank free pulses.
	// ----------------------------------------
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bank_free_o <= 10'h000;
		end else if (ce_i) begin
			bank_free_o <= bfree_nxt;
		end
	end

	// ----------------------------------------
	// Non-control bank release pulses.
	// ----------------------------------------
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fifo_release_o <= 10'h000;
		end else if (ce_i) begin
			fifo_release_o <= rel_nxt;
		end
	end

endmodule // uepif_flags

/* uepif_host.sv */
// Host model that reports IN banks as sent after a short or long delay.
`timescale 1ns/1ps
module uepif_host (
	input wire ref_clk_i,
	input wire rst_i,
	input wire slow_i,
	input wire [9:0] tx_send_i,
	input wire [9:0] fifo_release_i,
	input wire [9:0] in_ep_i,
	output wire [9:0] in_sent_o
);
reg [79:0] pipe_r;
always @(posedge ref_clk_i or posedge rst_i) begin
	if (rst_i)
		pipe_r <= 80'h0;
	else
		pipe_r <= {pipe_r[69:0], tx_send_i | (fifo_release_i & in_ep_i)};
end
assign in_sent_o = slow_i ? pipe_r[79:70] : pipe_r[9:0];
endmodule // uepif_host

/* uepif_monitor.sv */
// Port checker for the endpoint flag block.
`timescale 1ns/1ps
`include "uepif_defs.vh"
module uepif_monitor (
	input wire ref_clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire [31:0] bus_addr_i,
	input wire [31:0] bus_wdata_i,
	input wire bus_we_i,
	input wire bus_re_i,
	input wire [31:0] bus_rdata_o,
	input wire [9:0] tx_send_o,
	input wire [9:0] bank_free_o,
	input wire [9:0] fifo_release_o
);
function automatic bit h(input [31:0] a, input [31:0] b);
	h = (a >= b) && (a < b + 32'h28);
endfunction
default clocking cb @(posedge ref_clk_i); endclocking
default disable iff (rst_i);
chk_rdata_idle:
	assert property (ce_i && !bus_re_i |=> bus_rdata_o == 32'h0) else $error("rdata not idle");
chk_wo_read_zero:
	assert property (ce_i && bus_re_i && (h(bus_addr_i, `UEPIF_CLR_BASE)
		|| h(bus_addr_i, `UEPIF_SET_BASE)) |=> bus_rdata_o == 32'h0) else $error("wo read");
chk_send_cause:
	assert property (tx_send_o != 10'h0 |-> $past(bus_we_i) && $past(bus_wdata_i[0])
		&& h($past(bus_addr_i), `UEPIF_CLR_BASE)
		&& tx_send_o == 10'h1 << (($past(bus_addr_i) - `UEPIF_CLR_BASE) >> 2))
		else $error("send without clear");
chk_free_cause:
	assert property (bank_free_o != 10'h0 |-> $past(bus_we_i) && $past(bus_wdata_i[2:1]) != 2'h0
		&& bank_free_o == 10'h1 << (($past(bus_addr_i) - `UEPIF_CLR_BASE) >> 2))
		else $error("free without clear");
chk_release_cause:
	assert property (fifo_release_o != 10'h0 |-> $past(bus_we_i) && $past(bus_wdata_i[0])
		&& fifo_release_o == 10'h1 << (($past(bus_addr_i) - `UEPIF_FIFO_BASE) >> 2))
		else $error("release without write");
chk_send_pulse:
	assert property (tx_send_o != 10'h0 |=> (tx_send_o & $past(tx_send_o)) == 10'h0)
		else $error("send too long");
chk_free_pulse:
	assert property (bank_free_o != 10'h0 |=> (bank_free_o & $past(bank_free_o)) == 10'h0)
		else $error("free too long");
chk_release_pulse:
	assert property (fifo_release_o != 10'h0 |=> !(fifo_release_o & $past(fifo_release_o)))
		else $error("release too long");
cover property (tx_send_o != 10'h0);
cover property (bank_free_o != 10'h0);
cover property (fifo_release_o != 10'h0);
endmodule // uepif_monitor
bind uepif_flags uepif_monitor mon (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
	.bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_we_i(bus_we_i),
	.bus_re_i(bus_re_i), .bus_rdata_o(bus_rdata_o), .tx_send_o(tx_send_o),
	.bank_free_o(bank_free_o), .fifo_release_o(fifo_release_o));
